/* hdl/dacl_par_wr.sv */
// Parallel bus write cycle generator for the converter input latch
`timescale 1ns/100ps
`default_nettype none
module dacl_par_wr (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic serial_mode,
  input wire logic [dacl_pkg::DATA_W-1:0] word,
  output logic [dacl_pkg::DATA_W-1:0] dac_data,
  output logic dac_data_oe,
  output logic cs_n,
  output logic wr_n,
  output logic busy,
  output logic done
);

  // ---------------------------------------------------------------
  // State and timer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} dacl_pst_t;
  dacl_pst_t state_r; // Write cycle phase
  logic [3:0] tmr_r; // Cycles left in phase

  // Sequencer: setup, strobe low, release, hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      tmr_r <= 4'h0;
      dac_data <= '0;
      dac_data_oe <= 1'b0;
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Chip select parked low in serial mode selects the link
          cs_n <= !serial_mode;
          dac_data_oe <= 1'b0;
          if (start && !serial_mode) begin
            dac_data <= word;
            dac_data_oe <= 1'b1;
            cs_n <= 1'b0;
            busy <= 1'b1;
            tmr_r <= 4'(dacl_pkg::SETUP_CYC);
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Data settles before the strobe edge that latches it
          if (tmr_r <= 4'h1) begin
            wr_n <= 1'b0;
            tmr_r <= 4'(dacl_pkg::WR_CYC);
            state_r <= ST_STROBE;
          end else begin
            tmr_r <= tmr_r - 4'h1;
          end
        end
        ST_STROBE: begin
          if (tmr_r <= 4'h1) begin
            // Rising edge loads, and updates when load strobe is low
            wr_n <= 1'b1;
            state_r <= ST_HOLD;
          end else begin
            tmr_r <= tmr_r - 4'h1;
          end
        end
        ST_HOLD: begin
          // One cycle of hold after the rising edge, then release
          cs_n <= 1'b1;
          dac_data_oe <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* hdl/dacl_pkg.sv */
// Constants shared by the converter input-latch host controller
package dacl_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the AHB-Lite slave)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_LOAD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_DIV = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_SERIAL = 0; // 1 = serial link, 0 = parallel bus
  localparam int CTRL_LSB_FIRST = 1; // Serial bit order
  localparam int CTRL_STROBE = 2; // 1 = pulsed load strobe, 0 = held low
  localparam int CTRL_AUTO_LOAD = 3; // Pulse load after every word
  localparam int STAT_BUSY = 0;
  localparam int STAT_OVERRUN = 1;
  localparam int STAT_LOAD_PEND = 2;
  localparam int DATA_W = 14; // Converter word width
  localparam int FRAME_BITS = 16; // Bits per serial frame

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] DIV_RESET = 8'h04; // Half period, clocks

  // ---------------------------------------------------------------
  // Timing, clock is 100 ns
  // ---------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int SETUP_NS = 21; // Data before write strobe rises
  localparam int WR_PULSE_NS = 45; // Write strobe low time
  localparam int LOAD_PULSE_NS = 100; // Load strobe low time
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_CYC = (LOAD_PULSE_NS + CLK_NS - 1) / CLK_NS;

endpackage

/* hdl/dacl_ser_tx.sv */
// Serial frame transmitter with divided shift clock and low frame sync
`timescale 1ns/100ps
`default_nettype none
module dacl_ser_tx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic lsb_first,
  input wire logic [7:0] half_div,
  input wire logic [dacl_pkg::FRAME_BITS-1:0] frame,
  output logic sclk,
  output logic sync_n,
  output logic sdata,
  output logic busy,
  output logic done
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL} dacl_sst_t;
  dacl_sst_t state_r; // Frame phase
  logic [7:0] tmr_r; // Half period timer
  logic [4:0] falls_r; // Falling edges issued
  logic [dacl_pkg::FRAME_BITS-1:0] sh_r; // Bits still to send
  logic half_up; // Current half period over

  assign half_up = (tmr_r <= 8'h1);

  // Frame sequencer; clock idles high so each bit meets a falling edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      tmr_r <= 8'h0;
      falls_r <= 5'h0;
      sh_r <= '0;
      sclk <= 1'b1;
      sync_n <= 1'b1;
      sdata <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            // Sync goes low with the first bit, a half period early
            sync_n <= 1'b0;
            sdata <= lsb_first ? frame[0] : frame[15];
            sh_r <= frame;
            falls_r <= 5'h0;
            tmr_r <= half_div;
            busy <= 1'b1;
            state_r <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (half_up) begin
            // Falling edge: device samples the bit now stable
            sclk <= 1'b0;
            falls_r <= falls_r + 5'h1;
            tmr_r <= half_div;
            state_r <= ST_LOW;
          end else begin
            tmr_r <= tmr_r - 8'h1;
          end
        end
        ST_LOW: begin
          if (half_up) begin
            sclk <= 1'b1;
            tmr_r <= half_div;
            if (falls_r == 5'(dacl_pkg::FRAME_BITS)) begin
              // Sixteen edges done with sync still low
              state_r <= ST_TAIL;
            end else begin
              // Next bit changes on the rising edge
              sh_r <= lsb_first ? (sh_r >> 1) : (sh_r << 1);
              sdata <= lsb_first ? sh_r[1] : sh_r[14];
              state_r <= ST_HIGH;
            end
          end else begin
            tmr_r <= tmr_r - 8'h1;
          end
        end
        ST_TAIL: begin
          if (half_up) begin
            sync_n <= 1'b1;
            busy <= 1'b0;
            done <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            tmr_r <= tmr_r - 8'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* hdl/dacl_top.sv */
// Host controller for the converter input and output latches
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module dacl_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [dacl_pkg::DATA_W-1:0] dac_data,
  output logic dac_data_oe,
  output logic cs_n,
  output logic wr_n,
  output logic dac_latch_load_n,
  output logic sclk,
  output logic sync_n,
  output logic sdata,
  output logic bit_order_select,
  output logic alignment_select
);

  // ---------------------------------------------------------------
  // Bus phase capture
  // ---------------------------------------------------------------
  logic wr_pend_r; // Write data phase pending
  logic [7:0] addr_r; // Address of pending write
  logic addr_ok; // Valid address phase this cycle
  // Write decodes, true for one data-phase cycle
  logic wr_ctrl; // Control write
  logic wr_data; // Data write, starts a transfer
  logic wr_load; // Load request write
  logic wr_stat; // Status write
  logic wr_div; // Divider write

  // Only whole-word transfers are expected; size is not checked
  // A narrow write would still land as a full word
  assign addr_ok = hsel && htrans[1] && hready;

  // Register address phase so write data meets it one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h0;
    end else begin
      // Reads need no pending state
      wr_pend_r <= addr_ok && hwrite;
      // Address kept only for a taken transfer
      if (addr_ok) begin
        addr_r <= haddr;
      end
    end
  end

  // Unmapped writes match nothing and are lost
  assign wr_ctrl = wr_pend_r && (addr_r == dacl_pkg::ADDR_CTRL);
  assign wr_data = wr_pend_r && (addr_r == dacl_pkg::ADDR_DATA);
  assign wr_load = wr_pend_r && (addr_r == dacl_pkg::ADDR_LOAD);
  assign wr_stat = wr_pend_r && (addr_r == dacl_pkg::ADDR_STAT);
  assign wr_div = wr_pend_r && (addr_r == dacl_pkg::ADDR_DIV);

  // Zero wait states, always OKAY
  // Kept as flops so every output leaves a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [3:0] ctrl_r; // Mode bits
  logic [7:0] div_r; // Shift clock half period in clocks
  logic [dacl_pkg::DATA_W-1:0] word_r; // Last word written
  logic [15:0] count_r; // Words delivered
  logic busy; // Any transfer or strobe in flight
  logic ser_busy; // Serial frame running
  logic par_busy; // Parallel write running
  logic ser_done; // Frame finished pulse
  logic par_done; // Write finished pulse
  logic load_act_r; // Load strobe pulse running
  logic load_pend_r; // Load strobe waiting for a free link
  logic overrun_r; // Write refused while busy

  // Mode changes are refused mid-transfer to keep pins coherent
  // A divider change would also stretch a live frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= dacl_pkg::CTRL_RESET;
      div_r <= dacl_pkg::DIV_RESET;
    end else begin
      if (wr_ctrl && !busy) begin
        ctrl_r <= hwdata[3:0];
      end
      if (wr_div && !busy) begin
        // Zero would time the same as one in the divider; one is the fastest legal value
        div_r <= (hwdata[7:0] == 8'h0) ? 8'h01 : hwdata[7:0];
      end
    end
  end

  // Order and alignment straps follow the chosen bit order
  // One cycle behind control; no frame can be live then
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_order_select <= 1'b1;
      alignment_select <= 1'b0;
    end else begin
      bit_order_select <= !ctrl_r[dacl_pkg::CTRL_LSB_FIRST];
      alignment_select <= ctrl_r[dacl_pkg::CTRL_LSB_FIRST];
    end
  end

  // ---------------------------------------------------------------
  // Transfer start
  // ---------------------------------------------------------------
  logic go_ser_r; // Serial engine start pulse
  logic go_par_r; // Parallel engine start pulse
  logic [dacl_pkg::FRAME_BITS-1:0] frame; // Serial frame image

  // Start pulses count, so a second write cannot slip in
  assign busy = ser_busy || par_busy || load_act_r || load_pend_r
    || go_ser_r || go_par_r;

  // Word sits at the first-sent end of the frame, padding trails it
  // Padding reaches the device after the word is whole
  assign frame = ctrl_r[dacl_pkg::CTRL_LSB_FIRST] ? {2'b00, word_r}
    : {word_r, 2'b00};

  // A data write starts exactly one engine for the selected mode
  // The word register doubles as read-back of the last value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_r <= '0;
      go_ser_r <= 1'b0;
      go_par_r <= 1'b0;
    end else begin
      go_ser_r <= 1'b0;
      go_par_r <= 1'b0;
      if (wr_data && !busy) begin
        word_r <= hwdata[dacl_pkg::DATA_W-1:0];
        go_ser_r <= ctrl_r[dacl_pkg::CTRL_SERIAL];
        go_par_r <= !ctrl_r[dacl_pkg::CTRL_SERIAL];
      end
    end
  end

  // Overrun is sticky; a new refusal wins over a clear
  // Software learns of a lost write only from this flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_r <= 1'b0;
    end else if ((wr_data || wr_ctrl || wr_div) && busy) begin
      overrun_r <= 1'b1;
    end else if (wr_stat && hwdata[dacl_pkg::STAT_OVERRUN]) begin
      overrun_r <= 1'b0;
    end
  end

  // Delivered word counter
  // Wraps at its top; software should compare differences
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= 16'h0;
    end else if (ser_done || par_done) begin
      count_r <= count_r + 16'h1;
    end
  end

  // ---------------------------------------------------------------
  // Load strobe
  // ---------------------------------------------------------------
  logic [3:0] load_tmr_r; // Strobe low time left
  logic strobe_mode; // Load strobe pulsed rather than held low

  // Pulsed strobe lets software pick the update moment
  assign strobe_mode = ctrl_r[dacl_pkg::CTRL_STROBE];

  // Request, then pulse only with no serial frame or write running;
  // the strobe is its own pin, never merged with chip select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_pend_r <= 1'b0;
      load_act_r <= 1'b0;
      load_tmr_r <= 4'h0;
      dac_latch_load_n <= 1'b1;
    end else if (!strobe_mode) begin
      // Held low: each write or sixteenth edge updates directly
      // Requests are dropped; they mean nothing in this mode
      dac_latch_load_n <= 1'b0;
      load_pend_r <= 1'b0;
      load_act_r <= 1'b0;
    end else begin
      // Pulse running: count down its low time
      if (load_act_r) begin
        // Last low cycle: release the strobe
        if (load_tmr_r <= 4'h1) begin
          dac_latch_load_n <= 1'b1;
          load_act_r <= 1'b0;
        end else begin
          load_tmr_r <= load_tmr_r - 4'h1;
        end
      end else if (load_pend_r && !ser_busy && !par_busy
                   && !go_ser_r && !go_par_r) begin
        // Falling edge moves input latch to output latch
        dac_latch_load_n <= 1'b0;
        load_tmr_r <= 4'(dacl_pkg::LOAD_CYC);
        load_act_r <= 1'b1;
        load_pend_r <= 1'b0;
      end else begin
        // Idle: strobe stays high
        dac_latch_load_n <= 1'b1;
      end
      // Separate address write, or timed after each word
      // Set last, so a request meeting a pulse start is kept
      if (wr_load) begin
        load_pend_r <= 1'b1;
      end
      if ((ser_done || par_done) && ctrl_r[dacl_pkg::CTRL_AUTO_LOAD]) begin
        load_pend_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] rd_nxt; // Read word for this address phase

  // Unmapped addresses read as zero
  // Taken from the address phase, so no wait state is needed
  always_comb begin
    // Default first, so no bit is left as a latch
    rd_nxt = 32'h0;
    case (haddr)
      dacl_pkg::ADDR_CTRL: rd_nxt[3:0] = ctrl_r;
      dacl_pkg::ADDR_DATA: rd_nxt[dacl_pkg::DATA_W-1:0] = word_r;
      dacl_pkg::ADDR_STAT: begin
        rd_nxt[dacl_pkg::STAT_BUSY] = busy;
        rd_nxt[dacl_pkg::STAT_OVERRUN] = overrun_r;
        rd_nxt[dacl_pkg::STAT_LOAD_PEND] = load_pend_r || load_act_r;
      end
      dacl_pkg::ADDR_DIV: rd_nxt[7:0] = div_r;
      dacl_pkg::ADDR_COUNT: rd_nxt[15:0] = count_r;
      default: rd_nxt = 32'h0;
    endcase
  end

  // Read data lands for the data phase
  // Held between reads so a slow master still sees it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Engines
  // ---------------------------------------------------------------
  // Only one engine ever runs; both share the word register
  // Parallel engine also parks chip select low in serial mode
  dacl_par_wr u_par (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(go_par_r),
    .serial_mode(ctrl_r[dacl_pkg::CTRL_SERIAL]),
    .word(word_r),
    .dac_data(dac_data),
    .dac_data_oe(dac_data_oe),
    .cs_n(cs_n),
    .wr_n(wr_n),
    .busy(par_busy),
    .done(par_done)
  );

  // Serial engine derives the shift clock by division
  // The divider value is frozen while a frame runs
  dacl_ser_tx u_ser (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(go_ser_r),
    .lsb_first(ctrl_r[dacl_pkg::CTRL_LSB_FIRST]),
    .half_div(div_r),
    .frame(frame),
    .sclk(sclk),
    .sync_n(sync_n),
    .sdata(sdata),
    .busy(ser_busy),
    .done(ser_done)
  );

endmodule
`default_nettype wire

/* testbench/dacl_dev_model.sv */
// Behavioural model of the converter input and output latches
`timescale 1ns/100ps
`default_nettype none
module dacl_dev_model (
  input wire logic [13:0] dac_data,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic dac_latch_load_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdata,
  input wire logic bit_order_select,
  output logic [13:0] dac_out
);
  // ----------------------------------------------
  // Latches
  // ----------------------------------------------
  logic [13:0] in_latch; // Input latch
  logic [15:0] sr; // Serial shifter
  int cnt; // Falls seen in frame, 16 = idle
  logic kill; // Load strobe rose inside frame
  initial begin
    dac_out = 14'h0000;
    in_latch = 14'h0000;
    sr = 16'h0000;
    cnt = 16;
    kill = 1'b0;
  end
  // Parallel write; output only moves here when load is low
  always @(posedge wr_n) if (!cs_n) begin
    in_latch = dac_data;
    if (!dac_latch_load_n) dac_out = dac_data;
  end
  // New frame
  always @(negedge sync_n) begin
    cnt = 0;
    kill = 1'b0;
  end
  // Bits taken on falling edges only while framed
  always @(negedge sclk) if (!sync_n && cnt < 16) begin
    sr = bit_order_select ? {sr[14:0], sdata} : {sdata, sr[15:1]};
    cnt++;
    if (cnt == 16) begin
      in_latch = bit_order_select ? sr[15:2] : sr[13:0];
      if (!dac_latch_load_n && !kill) dac_out = in_latch;
    end
  end
  // Strobe rising mid frame cancels that word's update
  always @(posedge dac_latch_load_n) if (!sync_n && cnt < 16) kill = 1'b1;
  // Falling strobe loads unless a frame is in flight
  always @(negedge dac_latch_load_n) if (sync_n || cnt >= 16) begin
    dac_out = in_latch;
  end
endmodule
`default_nettype wire

/* testbench/dacl_top_sva.sv */
// Assertion checker for the converter latch host controller pins
`timescale 1ns/100ps
`default_nettype none
module dacl_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [dacl_pkg::DATA_W-1:0] dac_data,
  input wire logic dac_data_oe,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic dac_latch_load_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdata,
  input wire logic bit_order_select,
  input wire logic alignment_select
);
  // ----------------------------------------------
  // Helper logic
  // ----------------------------------------------
  logic sclk_d_r; // Shift clock one cycle back
  logic [4:0] fall_cnt_r; // Shift clock falls in this frame
  // Delayed shift clock for edge finding
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk;
    end
  end
  // Cleared between frames so counts never leak into the next one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fall_cnt_r <= 5'h00;
    end else if (sync_n) begin
      fall_cnt_r <= 5'h00;
    end else if (sclk_d_r && !sclk) begin
      fall_cnt_r <= fall_cnt_r + 5'h01;
    end
  end
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------
  // Properties
  // ----------------------------------------------
  property p_fall_in_frame; $fell(sclk) |-> !sync_n; endproperty
  a_fall_in_frame: assert property (p_fall_in_frame)
    else $error("shift clock fell outside a frame");
  property p_bit_steady; $fell(sclk) |-> $stable(sdata); endproperty
  a_bit_steady: assert property (p_bit_steady)
    else $error("serial data moved at a falling shift edge");
  property p_select_held; !sync_n |-> !cs_n; endproperty
  a_select_held: assert property (p_select_held)
    else $error("select not held during a frame");
  property p_bus_quiet; !sync_n |-> !dac_data_oe; endproperty
  a_bus_quiet: assert property (p_bus_quiet)
    else $error("parallel bus driven during a frame");
  property p_frame_bits; $rose(sync_n) |-> fall_cnt_r == 5'd16; endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame did not carry sixteen shift clocks");
  property p_wr_pulse; $fell(wr_n) |=> $rose(wr_n); endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe not one cycle low");
  property p_wr_data;
    !wr_n |-> !cs_n && dac_data_oe && $stable(dac_data);
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("bus data or select not steady under write strobe");
  property p_pin_pair; bit_order_select != alignment_select; endproperty
  a_pin_pair: assert property (p_pin_pair)
    else $error("order and alignment pins not complementary");
  property p_load_quiet;
    !sync_n && !$past(sync_n) |-> $stable(dac_latch_load_n);
  endproperty
  a_load_quiet: assert property (p_load_quiet)
    else $error("load strobe moved inside a frame");
  // Main scenarios reached
  c_frame: cover property ($rose(sync_n));
  c_write: cover property ($rose(wr_n));
  c_load: cover property ($fell(dac_latch_load_n) ##1 dac_latch_load_n);
endmodule
bind dacl_top dacl_sva sva_u (.hclk, .hresetn, .dac_data, .dac_data_oe,
  .cs_n, .wr_n, .dac_latch_load_n, .sclk, .sync_n, .sdata,
  .bit_order_select, .alignment_select);
`default_nettype wire

/* testbench/dacl_top_tb.sv */
// Self-checking bench for the converter latch host controller
`timescale 1ns/100ps
`default_nettype none
module dacl_top_tb;
  // ----------------------------------------------
  // Signals
  // ----------------------------------------------
  logic hclk = 1'b0; // 100 ns bus clock
  logic hresetn = 1'b0; // Held low for 20 cycles
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2; // Whole words only
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, dac_data_oe, cs_n, wr_n, dac_latch_load_n;
  logic sclk, sync_n, sdata, bit_order_select, alignment_select;
  logic [31:0] hrdata, r;
  logic [13:0] dac_data, dac_out;
  logic [3:0] c; // Control value this pass
  logic [3:0] modes [7] = '{4'h0, 4'h4, 4'hc, 4'h1, 4'h3, 4'h5, 4'hd};
  int errors = 0;
  int n_tests = 0;
  int seed = 32'h4bf97364;
  int exp_q[$]; // Words the output should show, oldest first
  int w, last_w = 0;
  always #50 hclk = ~hclk;
  dacl_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .dac_data,
    .dac_data_oe, .cs_n, .wr_n, .dac_latch_load_n, .sclk, .sync_n, .sdata,
    .bit_order_select, .alignment_select);
  dacl_dev_model dev_u (.dac_data, .cs_n, .wr_n, .dac_latch_load_n, .sclk,
    .sync_n, .sdata, .bit_order_select, .dac_out);
  // ----------------------------------------------
  // Tasks
  // ----------------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One single AHB transfer, held until ready is sampled
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  // Poll status until transfer and load are both finished
  task automatic wait_idle;
    logic [31:0] s;
    int k;
    repeat (4) @(posedge hclk);
    k = 0;
    do begin
      xfer(1'b0, dacl_pkg::ADDR_STAT, 32'h0, s);
      k++;
    end while ((s[0] | s[2]) !== 1'b0 && k < 500);
    if (k >= 500) errors++;
    repeat (2) @(posedge hclk);
  endtask
  // Verdict
  task automatic report_and_stop;
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog, roughly thirty times the expected run
  initial begin
    repeat (30000) @(posedge hclk);
    errors++;
    report_and_stop;
  end
  // ----------------------------------------------
  // Scenarios
  // ----------------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({cs_n, wr_n, sclk, sync_n, bit_order_select, alignment_select}, 6'h3e);
    // Every mode twice: parallel, serial, held, pulsed, auto
    for (int i = 0; i < 14; i++) begin
      c = modes[i % 7];
      xfer(1'b1, dacl_pkg::ADDR_CTRL, {28'h0, c}, r);
      xfer(1'b1, dacl_pkg::ADDR_DIV, 32'(1 + ($random(seed) & 3)), r);
      w = $random(seed) & 32'h3fff;
      exp_q.push_back(w);
      xfer(1'b1, dacl_pkg::ADDR_DATA, w, r);
      // Load asked for mid frame must wait for the frame end
      if (c == 4'h5) xfer(1'b1, dacl_pkg::ADDR_LOAD, 32'h0, r);
      // Mode change while busy must be refused
      if (c == 4'h3) xfer(1'b1, dacl_pkg::ADDR_CTRL, 32'h0, r);
      wait_idle;
      if (c == 4'h4) begin
        chk(dac_out, last_w);
        xfer(1'b1, dacl_pkg::ADDR_LOAD, 32'h0, r);
        wait_idle;
      end
      if (c == 4'h3) begin
        xfer(1'b0, dacl_pkg::ADDR_STAT, 32'h0, r);
        chk(r[1], 1'b1);
        xfer(1'b0, dacl_pkg::ADDR_CTRL, 32'h0, r);
        chk(r[3:0], 4'h3);
        xfer(1'b1, dacl_pkg::ADDR_STAT, 32'h2, r);
      end
      chk(dac_out, exp_q.pop_front());
      chk({bit_order_select, alignment_select}, c[1] ? 2'b01 : 2'b10);
      xfer(1'b0, dacl_pkg::ADDR_DATA, 32'h0, r);
      chk(r[13:0], w);
      last_w = w;
    end
    // Unmapped place reads as zero
    xfer(1'b0, 8'h20, 32'h0, r);
    chk(r, 32'h0);
    // Every word counted once; a zero divider reads back as one
    xfer(1'b0, dacl_pkg::ADDR_COUNT, 32'h0, r);
    chk(r, 32'he);
    xfer(1'b1, dacl_pkg::ADDR_DIV, 32'h0, r);
    xfer(1'b0, dacl_pkg::ADDR_DIV, 32'h0, r);
    chk(r, 32'h1);
    report_and_stop;
  end
endmodule
`default_nettype wire
